/* File: hw/omc_mode_ctrl.sv */
/*
  Operating-mode controller: mode sequencing, regulator enables, host reset,
  watchdog long window and development mode.
  Assumes pin inputs are asynchronous and the host talks over the serial link.
*/
`timescale 1ns/100ps
module omc_mode_ctrl #(
  parameter int unsigned RD_SHORT_CYCLES = omc_pkg::RD_SHORT_CYCLES,
  parameter int unsigned RD_LONG_CYCLES = omc_pkg::RD_LONG_CYCLES,
  parameter int unsigned LONG_WIN_CYCLES = omc_pkg::LONG_WIN_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Supervision, wake and strap pins
  input wire logic main_reg_undervolt,
  input wire logic can_wake,
  input wire logic hv_wake_input,
  input wire logic hv_sense_input,
  input wire logic gpio_wake,
  input wire logic overtemp,
  input wire logic dev_select,
  input wire logic cfg_restart_sel,
  // Supplies and host reset
  output logic main_regulator_output,
  output logic aux_regulator_output,
  output logic reset_output_n,
  // Status toward the rest of the chip
  output logic can_force_normal,
  output logic fail_safe_active,
  output omc_pkg::omc_state_type mode_state
);

  // ===========================================================================
  // Pin synchronisers
  logic [omc_pkg::PIN_COUNT-1:0] pin_raw, pin_m_q, pin_s_q;
  assign pin_raw = {cfg_restart_sel, dev_select, overtemp, gpio_wake,
                    hv_sense_input, hv_wake_input, can_wake, main_reg_undervolt};

  genvar gi;
  generate
    for (gi = 0; gi < omc_pkg::PIN_COUNT; gi++) begin : g_sync
      // Two flops per pin
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_m_q[gi] <= 1'b0;
          pin_s_q[gi] <= 1'b0;
        end else begin
          pin_m_q[gi] <= pin_raw[gi];
          pin_s_q[gi] <= pin_m_q[gi];
        end
      end
    end
  endgenerate

  // ===========================================================================
  // Serial receiver
  omc_pkg::omc_cmd_type cmd;
  logic cmd_valid;
  logic [15:0] status_word;
  omc_pkg::omc_state_type state_q, state_d;
  omc_pkg::omc_mode_type mode_field_q;
  logic dev_q, cfg_q, aux_en_q, wd_fail_flag_q, rd_long_q, ot_prev_q;
  logic [31:0] wd_cnt_q, dly_cnt_q;

  omc_spi_rx u_spi (
    .clk(clk),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_csn(spi_csn),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .status_word(status_word),
    .cmd(cmd),
    .cmd_valid(cmd_valid)
  );

  // Diagnosis word read back on every frame
  assign status_word = {state_q, mode_field_q, dev_q, cfg_q, wd_fail_flag_q,
                        aux_en_q, 7'h00};

  // ===========================================================================
  // Decoded events
  wire uv = pin_s_q[omc_pkg::PIN_UV];
  wire ot = pin_s_q[omc_pkg::PIN_OVERTEMP];
  wire wake_any = pin_s_q[omc_pkg::PIN_CAN_WAKE] | pin_s_q[omc_pkg::PIN_HV_WAKE]
                | pin_s_q[omc_pkg::PIN_HV_SENSE] | pin_s_q[omc_pkg::PIN_GPIO_WAKE];
  wire ot_cleared = ot_prev_q & ~ot;
  wire mode_wr = cmd_valid & cmd.write & (cmd.addr == omc_pkg::MODE_CTRL_ADDR);
  wire wd_trig = cmd_valid & cmd.write & (cmd.addr == omc_pkg::WD_CTRL_ADDR);
  wire [1:0] mode_req = cmd.data[omc_pkg::MODE_FIELD_LSB +: 2];
  wire soft_rst = mode_wr & (mode_req == omc_pkg::OMC_MODE_SOFT_RESET);
  wire wd_run = ~dev_q & ((state_q == omc_pkg::OMC_INIT)
              | (state_q == omc_pkg::OMC_NORMAL));
  wire wd_fail = wd_run & ~wd_trig & (wd_cnt_q == LONG_WIN_CYCLES - 1);
  wire rd_target_hit = rd_long_q ? (dly_cnt_q >= RD_LONG_CYCLES - 1)
                                 : (dly_cnt_q >= RD_SHORT_CYCLES - 1);
  wire supply_fail = uv & ((state_q == omc_pkg::OMC_INIT) | (state_q == omc_pkg::OMC_NORMAL)
                   | (state_q == omc_pkg::OMC_STOP));
  wire fail_to_fs = wd_fail & ~cfg_q;

  // ===========================================================================
  // Next mode
  always_comb begin
    state_d = state_q;
    case (state_q)
      omc_pkg::OMC_INIT: begin
        // Wake pins are not looked at here
        if (fail_to_fs)
          state_d = omc_pkg::OMC_FAIL_SAFE;
        else if (wd_fail || supply_fail)
          state_d = omc_pkg::OMC_RESTART;
        else if (soft_rst)
          state_d = omc_pkg::OMC_INIT;
        else if (cmd_valid)
          state_d = omc_pkg::OMC_NORMAL;
      end
      omc_pkg::OMC_NORMAL, omc_pkg::OMC_STOP: begin
        if (fail_to_fs)
          state_d = omc_pkg::OMC_FAIL_SAFE;
        else if (wd_fail || supply_fail)
          state_d = omc_pkg::OMC_RESTART;
        else if (mode_wr) begin
          case (mode_req)
            omc_pkg::OMC_MODE_NORMAL: state_d = omc_pkg::OMC_NORMAL;
            omc_pkg::OMC_MODE_SLEEP: state_d = omc_pkg::OMC_SLEEP;
            omc_pkg::OMC_MODE_STOP: state_d = omc_pkg::OMC_STOP;
            default: state_d = omc_pkg::OMC_INIT;
          endcase
        end
      end
      omc_pkg::OMC_SLEEP: begin
        if (wake_any)
          state_d = omc_pkg::OMC_RESTART;
      end
      omc_pkg::OMC_RESTART: begin
        if (!uv && rd_target_hit)
          state_d = omc_pkg::OMC_NORMAL;
      end
      omc_pkg::OMC_FAIL_SAFE: begin
        if (wake_any || ot_cleared)
          state_d = omc_pkg::OMC_RESTART;
      end
      default: state_d = omc_pkg::OMC_INIT;
    endcase
  end

  // ===========================================================================
  // Mode register and registered outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= omc_pkg::OMC_INIT;
      main_regulator_output <= 1'b1;
      reset_output_n <= 1'b1;
      fail_safe_active <= 1'b0;
    end else begin
      state_q <= state_d;
      main_regulator_output <= (state_d != omc_pkg::OMC_SLEEP)
                            && (state_d != omc_pkg::OMC_FAIL_SAFE);
      reset_output_n <= (state_d != omc_pkg::OMC_RESTART);
      fail_safe_active <= (state_d == omc_pkg::OMC_FAIL_SAFE);
    end
  end

  assign mode_state = state_q;
  assign aux_regulator_output = aux_en_q | dev_q;
  assign can_force_normal = dev_q;

  // ===========================================================================
  // Host-written mode and aux fields; mode field cleared while in Restart
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_field_q <= omc_pkg::OMC_MODE_NORMAL;
      aux_en_q <= 1'b0;
    end else if (state_q == omc_pkg::OMC_RESTART) begin
      mode_field_q <= omc_pkg::OMC_MODE_NORMAL;
    end else if (mode_wr) begin
      mode_field_q <= omc_pkg::omc_mode_type'(mode_req);
      aux_en_q <= cmd.data[omc_pkg::AUX_EN_BIT];
    end
  end

  // ===========================================================================
  // Straps: development select in Init, config in Init and while host held in reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dev_q <= 1'b0;
      cfg_q <= 1'b0;
    end else begin
      if (state_q == omc_pkg::OMC_INIT)
        dev_q <= pin_s_q[omc_pkg::PIN_DEV_SEL];
      if (state_q == omc_pkg::OMC_INIT || !reset_output_n)
        cfg_q <= pin_s_q[omc_pkg::PIN_CFG_SEL];
    end
  end

  // ===========================================================================
  // Watchdog long window and restart delay
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_cnt_q <= 32'h0;
      wd_fail_flag_q <= 1'b0;
      dly_cnt_q <= 32'h0;
      rd_long_q <= 1'b0;
      ot_prev_q <= 1'b0;
    end else begin
      ot_prev_q <= ot;
      wd_cnt_q <= (wd_run && !wd_trig && !wd_fail) ? wd_cnt_q + 32'h1 : 32'h0;
      if (wd_fail)
        wd_fail_flag_q <= 1'b1;
      else if (state_q == omc_pkg::OMC_NORMAL && wd_trig)
        wd_fail_flag_q <= 1'b0;
      if (state_q != omc_pkg::OMC_RESTART) begin
        dly_cnt_q <= 32'h0;
        rd_long_q <= (state_q != omc_pkg::OMC_SLEEP);
      end else if (!uv && !rd_target_hit) begin
        dly_cnt_q <= dly_cnt_q + 32'h1;
      end
    end
  end

  // ===========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_restart_holds_reset: assert property (
    state_q == omc_pkg::OMC_RESTART |-> !reset_output_n) else $error("reset released in restart");
  a_reset_release_normal: assert property (
    $rose(reset_output_n) |-> state_q == omc_pkg::OMC_NORMAL) else $error("reset released early");
  a_stop_reg_on: assert property (
    state_q == omc_pkg::OMC_STOP |-> main_regulator_output) else $error("regulator off in stop");
  a_sleep_reg_off: assert property (
    state_q == omc_pkg::OMC_SLEEP |-> !main_regulator_output) else $error("regulator on in sleep");
  a_failsafe_reg_off: assert property (
    state_q == omc_pkg::OMC_FAIL_SAFE |-> !main_regulator_output && fail_safe_active)
    else $error("regulator on in fail-safe");
  a_init_wake_ignored: assert property (
    state_q == omc_pkg::OMC_INIT && wake_any && !cmd_valid && !wd_fail && !uv
    |=> state_q == omc_pkg::OMC_INIT) else $error("wake acted on in init");
  a_init_cmd_normal: assert property (
    state_q == omc_pkg::OMC_INIT && cmd_valid && !soft_rst && !wd_fail && !uv
    |=> state_q == omc_pkg::OMC_NORMAL) else $error("init ignored command");
  a_dev_wd_stopped: assert property (
    dev_q |=> wd_cnt_q == 32'h0 && !wd_fail) else $error("watchdog runs in dev mode");
  a_dev_aux_can: assert property (
    dev_q |-> aux_regulator_output && can_force_normal) else $error("dev mode outputs wrong");
  a_restart_field_clear: assert property (
    state_q == omc_pkg::OMC_RESTART |=> mode_field_q == omc_pkg::OMC_MODE_NORMAL)
    else $error("mode field not cleared");
  a_wd_fail_target: assert property (
    wd_fail |=> (cfg_q ? state_q == omc_pkg::OMC_RESTART : state_q == omc_pkg::OMC_FAIL_SAFE))
    else $error("wrong watchdog failure target");

  c_restart_to_normal: cover property (
    state_q == omc_pkg::OMC_RESTART ##1 state_q == omc_pkg::OMC_NORMAL);
  c_enter_fail_safe: cover property ($rose(fail_safe_active));
  c_sleep_wake: cover property (
    state_q == omc_pkg::OMC_SLEEP ##1 state_q == omc_pkg::OMC_RESTART);

endmodule

/* File: hw/omc_pkg.sv */
/*
  Constants, types and timing for the operating-mode controller.
  Assumes a single 100 MHz system clock; serial link pins are asynchronous.
*/
package omc_pkg;

  // =========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned RD_SHORT_US = 10;
  localparam int unsigned RD_LONG_US = 100;
  localparam int unsigned LONG_WIN_MS = 200;
  localparam int unsigned RD_SHORT_CYCLES = RD_SHORT_US * CYC_PER_US;
  localparam int unsigned RD_LONG_CYCLES = RD_LONG_US * CYC_PER_US;
  localparam int unsigned LONG_WIN_CYCLES = LONG_WIN_MS * 1000 * CYC_PER_US;

  // =========================================================================
  // Serial frame layout
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned LONG_BITS = 32;
  localparam logic [6:0] MODE_CTRL_ADDR = 7'h01;
  localparam logic [6:0] WD_CTRL_ADDR = 7'h03;
  localparam int unsigned MODE_FIELD_LSB = 6;
  localparam int unsigned AUX_EN_BIT = 5;

  // =========================================================================
  // Pin vector positions
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned PIN_UV = 0;
  localparam int unsigned PIN_CAN_WAKE = 1;
  localparam int unsigned PIN_HV_WAKE = 2;
  localparam int unsigned PIN_HV_SENSE = 3;
  localparam int unsigned PIN_GPIO_WAKE = 4;
  localparam int unsigned PIN_OVERTEMP = 5;
  localparam int unsigned PIN_DEV_SEL = 6;
  localparam int unsigned PIN_CFG_SEL = 7;

  // =========================================================================
  // Types
  typedef enum logic [2:0] {
    OMC_INIT = 3'h0,
    OMC_NORMAL = 3'h1,
    OMC_STOP = 3'h3,
    OMC_SLEEP = 3'h2,
    OMC_RESTART = 3'h6,
    OMC_FAIL_SAFE = 3'h7
  } omc_state_type;

  typedef enum logic [1:0] {
    OMC_MODE_NORMAL = 2'h0,
    OMC_MODE_SLEEP = 2'h1,
    OMC_MODE_STOP = 2'h2,
    OMC_MODE_SOFT_RESET = 2'h3
  } omc_mode_type;

  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } omc_cmd_type;

endpackage

/* File: hw/omc_spi_rx.sv */
/*
  Serial slave for the mode controller: 16- or 32-bit frames, mode 0.
  Assumes clk is far faster than the link clock; all link pins are asynchronous.
*/
`timescale 1ns/100ps
module omc_spi_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link pins
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Status word shifted out, command taken in
  input wire logic [15:0] status_word,
  output omc_pkg::omc_cmd_type cmd,
  output logic cmd_valid
);

  // ===========================================================================
  // Synchronisers and edge detection
  logic [2:0] sclk_q, csn_q, mosi_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [5:0] cnt_q;

  // Two stages, then a third for edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 3'h0;
      csn_q <= 3'h7;
      mosi_q <= 3'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], spi_sclk};
      csn_q <= {csn_q[1:0], spi_csn};
      mosi_q <= {mosi_q[1:0], spi_mosi};
    end
  end

  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire cs_fall = ~csn_q[1] & csn_q[2];
  wire cs_rise = csn_q[1] & ~csn_q[2];
  wire selected = ~csn_q[1];
  wire frame_ok = (cnt_q == 6'(omc_pkg::WORD_BITS)) | (cnt_q == 6'(omc_pkg::LONG_BITS));

  // ===========================================================================
  // Receive shift and bit count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_q <= 16'h0;
      cnt_q <= 6'h0;
    end else if (cs_fall) begin
      cnt_q <= 6'h0;
    end else if (selected && sclk_rise) begin
      rx_q <= {rx_q[14:0], mosi_q[1]};
      cnt_q <= (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h1;
    end
  end

  // Frame end: only exact 16 or 32 bit frames count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd <= '0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= cs_rise & frame_ok;
      if (cs_rise && frame_ok)
        cmd <= omc_pkg::omc_cmd_type'(rx_q);
    end
  end

  // ===========================================================================
  // Transmit status, changed on falling link edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q <= 16'h0;
      spi_miso <= 1'b0;
    end else if (cs_fall) begin
      tx_q <= {status_word[14:0], 1'b0};
      spi_miso <= status_word[15];
    end else if (selected && sclk_fall) begin
      tx_q <= {tx_q[14:0], 1'b0};
      spi_miso <= tx_q[15];
    end
  end

endmodule

/* File: tb/omc_host_model.sv */
/*
  Host side of the serial link: a mode-0 master sending frames of up to 32 bits.
  Assumes clk is the 100 MHz system clock; the link clock idles low between frames.
*/
`timescale 1ns/100ps
module omc_host_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // Idle levels at time zero
  initial begin
    spi_sclk = 1'h0;
    spi_csn = 1'h1;
    spi_mosi = 1'h0;
  end

  // ==========================================
  // Frame transfer, 160 ns link clock, MSB first
  task automatic xfer(input logic [31:0] w, input int nb, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    @(posedge clk) spi_csn <= 1'h0;
    for (i = nb - 1; i >= 0; i--) begin
      @(posedge clk) spi_mosi <= w[i];
      repeat (7) @(posedge clk);
      spi_sclk <= 1'h1;
      if (i >= nb - 16) rx[i - nb + 16] = spi_miso;
      repeat (8) @(posedge clk);
      spi_sclk <= 1'h0;
    end
    repeat (8) @(posedge clk);
    spi_csn <= 1'h1;
    spi_mosi <= ~spi_mosi; // Released line shows no stale bit
    repeat (12) @(posedge clk);
  endtask
endmodule

/* File: tb/omc_mode_ctrl_bench.sv */
/*
  Self-checking bench of the operating-mode controller with a host model.
  Assumes shortened restart delays and watchdog window set below.
*/
`timescale 1ns/100ps
module omc_mode_ctrl_bench;
  // ==========================================
  // Shortened counts and signals
  localparam int RDS = 20;
  localparam int RDL = 40;
  localparam int WIN = 3000;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic spi_sclk;
  logic spi_csn;
  logic spi_mosi;
  logic spi_miso;
  logic uv = 1'h0;
  logic [3:0] wake = 4'h0;
  logic ot = 1'h0;
  logic dev = 1'h0;
  logic cfg = 1'h1;
  logic main_on;
  logic aux_on;
  logic rst_n;
  logic can_fn;
  logic fs_act;
  omc_pkg::omc_state_type st;
  logic [15:0] rx;
  int errors = 0;
  int n_tests = 0;

  // Clock
  always #5 clk = ~clk;

  // Design and host
  omc_mode_ctrl #(
    .RD_SHORT_CYCLES(RDS),
    .RD_LONG_CYCLES(RDL),
    .LONG_WIN_CYCLES(WIN)
  ) i_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_csn(spi_csn),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .main_reg_undervolt(uv),
    .can_wake(wake[0]),
    .hv_wake_input(wake[1]),
    .hv_sense_input(wake[2]),
    .gpio_wake(wake[3]),
    .overtemp(ot),
    .dev_select(dev),
    .cfg_restart_sel(cfg),
    .main_regulator_output(main_on),
    .aux_regulator_output(aux_on),
    .reset_output_n(rst_n),
    .can_force_normal(can_fn),
    .fail_safe_active(fs_act),
    .mode_state(st)
  );
  omc_host_model i_host (
    .clk(clk),
    .spi_sclk(spi_sclk),
    .spi_csn(spi_csn),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso)
  );

  // ==========================================
  // Shared helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic cmd(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer({16'h0000, 1'h1, a, d}, 16, rx);
  endtask
  task automatic trig();
    cmd(omc_pkg::WD_CTRL_ADDR, 8'h00);
  endtask
  task automatic pins(input logic [3:0] w, input logic u, input logic o);
    @(posedge clk);
    wake <= w;
    uv <= u;
    ot <= o;
  endtask
  task automatic wait_st(input omc_pkg::omc_state_type s, input int max, output int n);
    n = 0;
    while (st !== s && n < max) begin
      @(negedge clk);
      n++;
    end
    check(16'(st), 16'(s));
  endtask
  // Host reset low through Restart, then Normal within lo..hi cycles
  task automatic restart_walk(input int lo, input int hi);
    int n;
    n = 0;
    while (st === omc_pkg::OMC_RESTART && n < 2000) begin
      if (rst_n !== 1'h0) check(16'(rst_n), 16'h0);
      @(negedge clk);
      n++;
    end
    check(16'({st, rst_n}), {12'h0, omc_pkg::OMC_NORMAL, 1'h1});
    check(16'(n >= lo && n <= hi), 16'h1);
  endtask

  // ==========================================
  // Scenarios
  // Wakes and a 12-bit frame ignored in Init, 32-bit frame enters Normal
  task automatic t_init();
    check(16'({st, main_on, rst_n, fs_act}), 16'h06);
    pins(4'hf, 1'h0, 1'h0);
    i_host.xfer(32'h0000_0a5a, 12, rx);
    check(16'(st), 16'(omc_pkg::OMC_INIT));
    pins(4'h0, 1'h0, 1'h0);
    i_host.xfer(32'h1234_8300, 32, rx);
    check(16'(st), 16'(omc_pkg::OMC_NORMAL));
    check(16'({can_fn, aux_on}), 16'h0);
  endtask
  // Stop, then Sleep woken by each wake pin
  task automatic t_sleep();
    int i;
    int n;
    cmd(omc_pkg::MODE_CTRL_ADDR, 8'h80);
    check(16'({st, main_on}), {12'h0, omc_pkg::OMC_STOP, 1'h1});
    trig();
    check(16'(rx[12:11]), 16'(omc_pkg::OMC_MODE_STOP));
    cmd(omc_pkg::MODE_CTRL_ADDR, 8'h20);
    check(16'({st, aux_on}), {12'h0, omc_pkg::OMC_NORMAL, 1'h1});
    for (i = 0; i < 4; i++) begin
      cmd(omc_pkg::MODE_CTRL_ADDR, 8'h40);
      check(16'({st, main_on}), {12'h0, omc_pkg::OMC_SLEEP, 1'h0});
      pins(4'h1 << i, 1'h0, 1'h0);
      wait_st(omc_pkg::OMC_RESTART, 10, n);
      pins(4'h0, 1'h0, 1'h0);
      restart_walk(RDS - 2, RDS + 6);
      trig();
      check(16'(rx[15:11]), 16'h04);
    end
  endtask
  // Undervoltage holds Restart until it clears
  task automatic t_uv();
    int n;
    trig();
    pins(4'h0, 1'h1, 1'h0);
    wait_st(omc_pkg::OMC_RESTART, 10, n);
    repeat (100) @(negedge clk);
    check(16'({st, rst_n}), {12'h0, omc_pkg::OMC_RESTART, 1'h0});
    pins(4'h0, 1'h0, 1'h0);
    restart_walk(0, RDL + 6);
  endtask
  // Missing trigger with restart strap
  task automatic t_wd();
    int n;
    trig();
    wait_st(omc_pkg::OMC_RESTART, WIN + 50, n);
    check(16'(n >= WIN - 30), 16'h1);
    restart_walk(RDL - 2, RDL + 6);
    trig();
    check(16'(rx[10:8]), 16'h3);
  endtask
  // Fail-Safe strap: each wake pin, then overtemp clearing, leaves it
  task automatic t_fs();
    int i;
    int n;
    @(posedge clk) cfg <= 1'h0;
    cmd(omc_pkg::MODE_CTRL_ADDR, 8'hc0);
    check(16'(st), 16'(omc_pkg::OMC_INIT));
    for (i = 0; i < 5; i++) begin
      trig();
      wait_st(omc_pkg::OMC_FAIL_SAFE, WIN + 50, n);
      check(16'({main_on, fs_act}), 16'h1);
      pins(4'h0, 1'h0, i == 4);
      repeat (100) @(negedge clk);
      check(16'(st), 16'(omc_pkg::OMC_FAIL_SAFE));
      pins(i < 4 ? 4'h1 << i : 4'h0, 1'h0, 1'h0);
      wait_st(omc_pkg::OMC_RESTART, 10, n);
      pins(4'h0, 1'h0, 1'h0);
      restart_walk(RDL - 2, RDL + 6);
    end
  endtask
  // Development strap: watchdog stopped, aux on, CAN forced, Sleep allowed
  task automatic t_dev();
    int n;
    @(posedge clk) dev <= 1'h1;
    cfg <= 1'h1;
    cmd(omc_pkg::MODE_CTRL_ADDR, 8'hc0);
    trig();
    check(16'({st, can_fn, aux_on}), {11'h0, omc_pkg::OMC_NORMAL, 2'h3});
    repeat (WIN + 200) @(negedge clk);
    check(16'(st), 16'(omc_pkg::OMC_NORMAL));
    cmd(omc_pkg::MODE_CTRL_ADDR, 8'h40);
    check(16'({st, main_on, aux_on}), {11'h0, omc_pkg::OMC_SLEEP, 2'h1});
    pins(4'h4, 1'h0, 1'h0);
    wait_st(omc_pkg::OMC_RESTART, 10, n);
    pins(4'h0, 1'h0, 1'h0);
    restart_walk(RDS - 2, RDS + 6);
    check(16'({can_fn, aux_on}), 16'h3);
  endtask

  // ==========================================
  // Verdict and sequence
  task automatic give_verdict();
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Reset, then the scenarios in order
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clk);
    t_init();
    t_sleep();
    t_uv();
    t_wd();
    t_fs();
    t_dev();
    give_verdict();
  end
  // Hang guard, about three times the expected run
  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
endmodule
